// File: common/rsb_regs.vh
// Constants for the reset strap capture and boot select block.
// Assumes inclusion by bare name from a design file.
`ifndef RSB_REGS_VH
`define RSB_REGS_VH
`define RSB_CAP_W        6
`define RSB_CAP_IF0      0
`define RSB_CAP_IF1      1
`define RSB_CAP_AC_LO    2
`define RSB_CAP_AC_HI    4
`define RSB_CAP_TEST     5
`define RSB_CAP_RST      6'h00
`define RSB_AC_PROG      3'h0
`define RSB_AC_NOAUTO    3'h3
`define RSB_IF_PROG      2'h3
`define RSB_ADDR_W       7
`define RSB_ADDR_BASE    7'h70
`define RSB_DEV_ID       12'hA5C
`define RSB_REV_ID       4'h1
`define RSB_IDW          8
`define RSB_ID_RST       8'h00
`define RSB_ST_WAIT      3'h0
`define RSB_ST_CAPT      3'h1
`define RSB_ST_FETCH     3'h2
`define RSB_ST_DONE      3'h3
`define RSB_ST_TEST      3'h4
`define RSB_ST_PROG      3'h5
`define RSB_ZERO3        3'h0
`endif

// File: logic/rsb_top.v
// Reset strap capture and boot select controller.
// Assumes strap pins, reset_in_low and all control inputs are synchronous to clk.
`timescale 1ns/10ps
`include "rsb_regs.vh"
module rsb_top #(
  parameter INT_EEPROM = 1'b0                      // 1 for internal EEPROM variant
) (
  input  wire        clk,                          // ring oscillator clock
  input  wire        rst,                          // synchronous reset, high
  input  wire        reset_in_low,                 // device reset pin, low active
  input  wire [5:0]  strap_pins,                   // dual-purpose pin levels
  input  wire        fetch_done,                   // image fetch finished pulse
  input  wire        addr_wr,                      // serial address write strobe
  input  wire [6:0]  addr_wdata,                   // serial address write data
  input  wire        ring_osc_off_wr,              // request oscillator off
  input  wire        host_select_n,                // host chip select, low active
  output reg  [5:0]  strap_capture_reg,            // captured strap values
  output reg         test_mode,                    // manufacturing test active
  output reg  [2:0]  test_sel,                     // selected test mode
  output reg         eeprom_prog_mode,             // direct EEPROM programming
  output reg         skip_autocfg,                 // boot without auto-configuration
  output reg  [2:0]  boot_config_select,           // image index
  output reg         host_if_i2c,                  // 1 I2C, 0 SPI host mode
  output reg         boot_from_rom,                // 1 ROM, 0 EEPROM source
  output reg  [6:0]  serial_addr_reg,              // I2C slave address
  output reg         fetch_start,                  // start image fetch pulse
  output reg         boot_done_flag,               // auto-configuration complete
  output reg         ring_osc_off,                 // oscillator disabled
  output reg         eeprom_sel_n,                 // EEPROM select, low active
  output reg         host_access_en,               // host may use boot results
  output reg         runtime_mode,                 // pins in run-time roles
  output reg  [7:0]  ident_reg_lo,                 // ID high byte
  output reg  [7:0]  ident_reg_hi                  // ID low nibble and revision
);


  localparam [11:0] DEV_ID = `RSB_DEV_ID;
  localparam [3:0]  REV_ID = `RSB_REV_ID;

  reg        rst_pin_d;
  reg  [2:0] state;
  reg  [2:0] next_state;
  wire       rise;
  wire       test;
  wire [2:0] ac;
  wire [1:0] pif;
  wire       in_capt;
  wire       in_fetch;
  wire       past_capt;
  wire       cap_prog;
  wire       cap_skip;
  wire       going_done;
  wire       ext_fetch;
  wire       unused_sel;

  assign rise       = reset_in_low & ~rst_pin_d;
  assign test       = strap_capture_reg[`RSB_CAP_TEST];
  assign ac         = strap_capture_reg[`RSB_CAP_AC_HI:`RSB_CAP_AC_LO];
  assign pif        = strap_capture_reg[`RSB_CAP_IF1:`RSB_CAP_IF0];
  assign in_capt    = (state == `RSB_ST_CAPT);
  assign in_fetch   = (state == `RSB_ST_FETCH);
  assign past_capt  = (state != `RSB_ST_WAIT) && (state != `RSB_ST_CAPT);
  assign cap_prog   = test && (ac == `RSB_AC_PROG) && (pif == `RSB_IF_PROG) && INT_EEPROM;
  assign cap_skip   = test && (ac == `RSB_AC_NOAUTO);
  assign going_done = reset_in_low && (next_state == `RSB_ST_DONE || state == `RSB_ST_DONE);
  assign ext_fetch  = in_fetch && !boot_from_rom && !INT_EEPROM;
  // host_select_n is consumed by the asynchronous host port outside this block.
  assign unused_sel = host_select_n;

  always @* begin
    next_state = state;
    case (state)
      `RSB_ST_WAIT: begin
        if (rise) begin
          next_state = `RSB_ST_CAPT;
        end
      end
      `RSB_ST_CAPT: begin
        // Programming mode exists only on the internal EEPROM variant; the
        // same straps elsewhere fall through to an ordinary test mode.
        if (cap_prog) begin
          next_state = `RSB_ST_PROG;
        end else if (cap_skip) begin
          next_state = `RSB_ST_DONE;
        end else if (test) begin
          next_state = `RSB_ST_TEST;
        end else begin
          next_state = `RSB_ST_FETCH;
        end
      end
      `RSB_ST_FETCH: begin
        if (fetch_done) begin
          next_state = `RSB_ST_DONE;
        end
      end
      `RSB_ST_DONE: begin
        next_state = `RSB_ST_DONE;
      end
      `RSB_ST_TEST: begin
        next_state = `RSB_ST_TEST;
      end
      `RSB_ST_PROG: begin
        next_state = `RSB_ST_PROG;
      end
      default: next_state = `RSB_ST_WAIT;
    endcase
    // A falling reset pin aborts any boot step and waits for the next edge.
    if (!reset_in_low) begin
      next_state = `RSB_ST_WAIT;
    end
  end

  // The pin is registered once so that its rising edge is seen for exactly
  // one cycle; reset parks the copy low so a pin held high at power-up counts.
  always @(posedge clk) begin
    if (rst) begin
      rst_pin_d <= 1'b0;
    end else begin
      rst_pin_d <= reset_in_low;
    end
  end

  // The whole sequence runs on clk, the ring oscillator, so it needs no
  // external reference clock.
  always @(posedge clk) begin
    if (rst) begin
      state <= `RSB_ST_WAIT;
    end else begin
      state <= next_state;
    end
  end

  // Capture only on the pin edge; the value is frozen until the pin rises again.
  always @(posedge clk) begin
    if (rst) begin
      strap_capture_reg <= `RSB_CAP_RST;
    end else if (rise) begin
      strap_capture_reg <= strap_pins;
    end
  end

  // Decodes come from the stored capture one cycle after the edge, so they
  // never see the pins once they have taken their run-time roles.
  always @(posedge clk) begin
    if (rst) begin
      test_mode <= 1'b0;
    end else if (in_capt) begin
      test_mode <= test;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      test_sel <= `RSB_ZERO3;
    end else if (in_capt) begin
      test_sel <= ac;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      eeprom_prog_mode <= 1'b0;
    end else if (in_capt) begin
      eeprom_prog_mode <= cap_prog;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      skip_autocfg <= 1'b0;
    end else if (in_capt) begin
      skip_autocfg <= cap_skip;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      boot_config_select <= `RSB_ZERO3;
    end else if (in_capt) begin
      boot_config_select <= ac;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      host_if_i2c <= 1'b0;
    end else if (in_capt) begin
      host_if_i2c <= pif[`RSB_CAP_IF1];
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      boot_from_rom <= 1'b0;
    end else if (in_capt) begin
      boot_from_rom <= INT_EEPROM ? 1'b0 : pif[`RSB_CAP_IF0];
    end
  end

  // The strap value is only a default; a later write may load any address.
  always @(posedge clk) begin
    if (rst) begin
      serial_addr_reg <= `RSB_ADDR_BASE;
    end else if (in_capt) begin
      serial_addr_reg <= `RSB_ADDR_BASE | {{(`RSB_ADDR_W - 2){1'b0}}, pif};
    end else if (addr_wr && past_capt) begin
      serial_addr_reg <= addr_wdata;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      fetch_start <= 1'b0;
    end else begin
      fetch_start <= in_capt && (next_state == `RSB_ST_FETCH);
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      boot_done_flag <= 1'b0;
    end else if (!reset_in_low) begin
      boot_done_flag <= 1'b0;
    end else if (going_done) begin
      boot_done_flag <= 1'b1;
    end
  end

  // The host port stays locked out until boot results exist.
  always @(posedge clk) begin
    if (rst) begin
      host_access_en <= 1'b0;
    end else if (!reset_in_low) begin
      host_access_en <= 1'b0;
    end else if (going_done) begin
      host_access_en <= 1'b1;
    end
  end

  // Stopping the oscillator early would strand the boot sequence, so the
  // request is ignored until boot is done.
  always @(posedge clk) begin
    if (rst) begin
      ring_osc_off <= 1'b0;
    end else if (!reset_in_low) begin
      ring_osc_off <= 1'b0;
    end else if (ring_osc_off_wr && boot_done_flag) begin
      ring_osc_off <= 1'b1;
    end
  end

  // Device drives EEPROM select only while fetching from external EEPROM;
  // otherwise it is held inactive so a host may share the serial wires.
  always @(posedge clk) begin
    if (rst) begin
      eeprom_sel_n <= 1'b1;
    end else begin
      eeprom_sel_n <= !ext_fetch;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      runtime_mode <= 1'b0;
    end else begin
      runtime_mode <= reset_in_low & ((state != `RSB_ST_WAIT) | rise);
    end
  end

  // Identification is constant but registered so every output is a flip-flop.
  always @(posedge clk) begin
    if (rst) begin
      ident_reg_lo <= `RSB_ID_RST;
    end else begin
      ident_reg_lo <= DEV_ID[11:4];
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      ident_reg_hi <= `RSB_ID_RST;
    end else begin
      ident_reg_hi <= {DEV_ID[3:0], REV_ID};
    end
  end

endmodule // rsb_top

// File: verif/rsb_checker.sv
// Assertions on the strap capture and boot select ports.
// Assumes a bind onto rsb_top, connected by port name.
`timescale 1ns/10ps
`include "rsb_regs.vh"
module rsb_checker #(
  parameter INT_EEPROM = 1'b0                         // variant with internal EEPROM
) (
  input wire       clk,                  // boot clock
  input wire       rst,                  // synchronous reset
  input wire       reset_in_low,         // device reset pin
  input wire       fetch_done,           // fetch finished
  input wire       addr_wr,              // address write strobe
  input wire       ring_osc_off_wr,      // oscillator off request
  input wire [5:0] strap_pins,           // strap pins
  input wire [5:0] strap_capture_reg,    // captured straps
  input wire [6:0] addr_wdata,           // address write data
  input wire [6:0] serial_addr_reg,      // serial address
  input wire [2:0] boot_config_select,   // image index
  input wire [2:0] test_sel,             // test mode select
  input wire [7:0] ident_reg_lo,         // identification low
  input wire [7:0] ident_reg_hi,         // identification high
  input wire       test_mode,            // test mode
  input wire       eeprom_prog_mode,     // programming mode
  input wire       skip_autocfg,         // skip boot
  input wire       host_if_i2c,          // host mode
  input wire       boot_from_rom,        // boot source
  input wire       fetch_start,          // fetch start
  input wire       boot_done_flag,       // boot done
  input wire       ring_osc_off,         // oscillator off
  input wire       eeprom_sel_n,         // EEPROM select
  input wire       host_access_en        // host access
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  property p_cap; $rose(reset_in_low) |=> strap_capture_reg == $past(strap_pins); endproperty
  a_cap: assert property (p_cap) else $error("strap capture wrong");
  property p_hold; !$rose(reset_in_low) |=> $stable(strap_capture_reg); endproperty
  a_hold: assert property (p_hold) else $error("capture changed");
  property p_dec; $rose(reset_in_low) |=> ##1 boot_config_select == $past(strap_pins[4:2], 2)
    && host_if_i2c == $past(strap_pins[1], 2)
    && boot_from_rom == (!INT_EEPROM && $past(strap_pins[0], 2)); endproperty
  a_dec: assert property (p_dec) else $error("decode wrong");
  property p_test; $rose(reset_in_low) && strap_pins[5] && strap_pins[4:2] != 3'h3
    && strap_pins[4:2] != 3'h0 |=> ##1 test_mode && test_sel == $past(strap_pins[4:2], 2);
  endproperty
  a_test: assert property (p_test) else $error("test mode wrong");
  property p_prog; $rose(reset_in_low) |=> ##1
    eeprom_prog_mode == (INT_EEPROM && $past(strap_pins, 2) == 6'h23); endproperty
  a_prog: assert property (p_prog) else $error("program mode wrong");
  property p_skip; $rose(reset_in_low) && strap_pins[5:2] == 4'hB |=>
    ##1 skip_autocfg && boot_done_flag && !fetch_start; endproperty
  a_skip: assert property (p_skip) else $error("skip wrong");
  property p_fetch; $rose(reset_in_low) && !strap_pins[5] |=> !fetch_start ##1 fetch_start;
  endproperty
  a_fetch: assert property (p_fetch) else $error("fetch start wrong");
  property p_sel; fetch_start && !boot_from_rom && !INT_EEPROM |=> !eeprom_sel_n; endproperty
  a_sel: assert property (p_sel) else $error("eeprom select wrong");
  property p_done; $rose(boot_done_flag) |-> $past(fetch_done) || skip_autocfg; endproperty
  a_done: assert property (p_done) else $error("early done");
  property p_osc; $rose(ring_osc_off) |-> boot_done_flag && $past(ring_osc_off_wr); endproperty
  a_osc: assert property (p_osc) else $error("oscillator off wrong");
  property p_addr; addr_wr && boot_done_flag |=> serial_addr_reg == $past(addr_wdata); endproperty
  a_addr: assert property (p_addr) else $error("address write lost");
  property p_id; !$past(rst) |-> {ident_reg_lo, ident_reg_hi} == {`RSB_DEV_ID, `RSB_REV_ID};
  endproperty
  a_id: assert property (p_id) else $error("identification wrong");
  property p_host; host_access_en |-> boot_done_flag; endproperty
  a_host: assert property (p_host) else $error("host access early");
  c_done: cover property ($rose(boot_done_flag));
  c_skip: cover property ($rose(skip_autocfg));
  c_osc: cover property ($rose(ring_osc_off));
endmodule // rsb_checker

// File: verif/rsb_board.sv
// Board straps and SPI EEPROM seen from the boot controller.
// Assumes fetch_start is a one-cycle pulse on clk.
`timescale 1ns/10ps
module rsb_board (
  input  wire       clk, reset_in_low, fetch_start, slow, // control
  input  wire [5:0] strap_val,                             // resistor levels
  output wire [5:0] strap_pins,                            // shared pins
  output reg        fetch_done = 1'b0                      // image read finished
);
  reg       rl_q = 1'b0;
  reg [5:0] pat = 6'h15;
  reg [3:0] cnt = 4'h0;
  // Straps hold through the rising edge; then pins toggle in run-time use.
  assign strap_pins = (reset_in_low & rl_q) ? pat : strap_val;
  always @(posedge clk) begin
    rl_q <= reset_in_low;
    pat <= pat + 6'h25;
    fetch_done <= (cnt == 4'h1);
    if (fetch_start) begin
      cnt <= slow ? 4'h9 : 4'h2;
    end else if (cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
    end
  end
endmodule // rsb_board

// File: verif/testbench.sv
// Self-checking bench for the strap capture and boot select block.
// Assumes the external EEPROM variant of rsb_top.
`timescale 1ns/10ps
`include "rsb_regs.vh"
module testbench;
  reg clk = 1'b0, rst = 1'b1, reset_in_low = 1'b0, addr_wr = 1'b0, ring_osc_off_wr = 1'b0;
  reg host_select_n = 1'b1, slow = 1'b0;
  reg [5:0] sv = 6'h00;
  reg [6:0] addr_wdata = 7'h2B;
  integer fail_count = 0, compares = 0, k;
  wire [5:0] strap_pins, strap_capture_reg;
  wire [2:0] test_sel, boot_config_select;
  wire [6:0] serial_addr_reg;
  wire [7:0] ident_reg_lo, ident_reg_hi;
  wire fetch_done, test_mode, eeprom_prog_mode, skip_autocfg, host_if_i2c, boot_from_rom;
  wire fetch_start, boot_done_flag, ring_osc_off, eeprom_sel_n, host_access_en, runtime_mode;
  rsb_top i_dut (.*);
  rsb_board i_board (.clk(clk), .reset_in_low(reset_in_low), .fetch_start(fetch_start),
    .slow(slow), .strap_val(sv), .strap_pins(strap_pins), .fetch_done(fetch_done));
  initial forever #25 clk = ~clk;
  task tally_and_finish; begin
    if (fail_count == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  end endtask
  task chk(input [15:0] got, input [15:0] exp); begin
    compares = compares + 1;
    if (got !== exp) begin
      fail_count = fail_count + 1;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  end endtask
  task step; begin @(posedge clk) #2; end endtask
  task pulse(input a, input o); begin
    addr_wr = a; ring_osc_off_wr = o; step; addr_wr = 1'b0; ring_osc_off_wr = 1'b0; step;
  end endtask
  task boot(input [5:0] s, input sl); integer i; reg ex; begin
    ex = !s[5] || s[4:2] == 3'h3;
    sv = s; slow = sl; reset_in_low = 1'b0; step; step; reset_in_low = 1'b1;
    step; step; chk(strap_capture_reg, s);
    step; chk(boot_config_select, s[4:2]); chk(host_if_i2c, s[1]);
    chk(boot_from_rom, s[0]); chk(serial_addr_reg, {5'h1C, s[1:0]});
    step; chk(eeprom_sel_n, s[5] | s[0]);
    for (i = 0; i < 14 && boot_done_flag !== 1'b1; i = i + 1) step;
    if (boot_done_flag !== 1'b1 && ex) begin fail_count = fail_count + 1; tally_and_finish; end
    chk(boot_done_flag, ex); chk(strap_capture_reg, s); chk(runtime_mode, 1);
    chk(host_access_en, ex);
    chk({ident_reg_lo, ident_reg_hi}, {`RSB_DEV_ID, `RSB_REV_ID});
  end endtask
  initial begin
    repeat (8) @(posedge clk); #2 rst = 1'b0;
    for (k = 0; k < 8; k = k + 1) boot({1'b0, k[2:0], k[1:0]}, k[0]);
    pulse(1, 0); chk(serial_addr_reg, 7'h2B);
    pulse(0, 1); chk(ring_osc_off, 1);
    boot(6'h2C, 0); chk(skip_autocfg, 1);
    boot(6'h23, 0); chk(eeprom_prog_mode, 0);
    pulse(0, 1); chk(ring_osc_off, 0);
    boot(6'h34, 0); chk(test_mode, 1); chk(test_sel, 3'h5);
    tally_and_finish;
  end
endmodule // testbench
bind rsb_top rsb_checker #(.INT_EEPROM(INT_EEPROM)) i_chk (.*);
